// >>> verilog/epg_pkg.sv
package epg_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int PWR_W = 16;
	localparam int ACC_W = 48;
	localparam int TMR_W = 32;

	// ************************************************************
	// timing, clock is 250 MHz
	// ************************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int NS_PER_MS     = 1000000;
	localparam int CTR_PULSE_MS  = 275;
	localparam int CF_PULSE_MS   = 90;
	localparam int CTR_SHORT_MS  = 550;
	localparam int CF_SHORT_MS   = 180;
	localparam int CTR_PULSE_CYC = CTR_PULSE_MS * (NS_PER_MS / CLK_PERIOD_NS);
	localparam int CF_PULSE_CYC  = CF_PULSE_MS * (NS_PER_MS / CLK_PERIOD_NS);

	// ************************************************************
	// digital-to-frequency scaling
	// ************************************************************
	// full-scale power gives 0.4 x base frequency on the counter outputs;
	// quantum = full_scale * 2^(21-sel) / 0.4 = full_scale * 5 * 2^(20-sel)
	localparam int PWR_FS        = (2 ** PWR_W) - 1;
	localparam int QUANT_MANT    = PWR_FS * 5;
	localparam int BASE_DIV_EXP  = 20;
	localparam int CF_EXP_SCF_HI = 7;
	localparam int CF_EXP_SCF_LO = 6;

	// creep threshold: 0.0014 % of full scale, i.e. 14 per million
	localparam int NOLOAD_PPM    = 14;
	localparam int PPM_DIV       = 1000000;
	localparam int NOLOAD_MIN    = (PWR_FS * NOLOAD_PPM + PPM_DIV - 1) / PPM_DIV;

	// ************************************************************
	// reset values of the outputs
	// ************************************************************
	localparam logic CTR_IDLE = 1'b1;
	localparam logic CF_IDLE  = 1'b0;

	// ************************************************************
	// state of the pulse generator
	// ************************************************************
	typedef struct packed {
		logic             mclk_d;
		logic [ACC_W-1:0] acc_ctr;
		logic [ACC_W-1:0] acc_cf;
		logic [TMR_W-1:0] ctr_tmr;
		logic [TMR_W-1:0] ctr_per;
		logic [TMR_W-1:0] cf_tmr;
		logic [TMR_W-1:0] cf_per;
		logic             next_b;
		logic             pulse_a_n;
		logic             pulse_b_n;
		logic             calib;
	} epg_state_t;

endpackage

// >>> verilog/epg_pulse_gen.sv
`timescale 1ns/1ps
module epg_pulse_gen #(
	parameter logic [epg_pkg::TMR_W-1:0] CTR_W_CYC =
		epg_pkg::TMR_W'(epg_pkg::CTR_PULSE_CYC),
	parameter logic [epg_pkg::TMR_W-1:0] CF_W_CYC =
		epg_pkg::TMR_W'(epg_pkg::CF_PULSE_CYC)
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_nrst,
	input  wire logic                      i_master_clock_in,
	input  wire logic [epg_pkg::PWR_W-1:0] i_power,
	input  wire logic                      i_base_freq_sel_lo,
	input  wire logic                      i_base_freq_sel_hi,
	input  wire logic                      i_calib_scale_sel,
	output logic                           o_counter_pulse_a_n,
	output logic                           o_counter_pulse_b_n,
	output logic                           o_calib_pulse_out
);

	// ************************************************************
	// helpers
	// ************************************************************
	// quantum of one counter-drive pulse for the selected base frequency
	function automatic logic [epg_pkg::ACC_W-1:0] epg_ctr_quantum(
		input logic [1:0] sel
	);
		logic [5:0] sh;
		sh = 6'(epg_pkg::BASE_DIV_EXP) - {4'h0, sel};
		return epg_pkg::ACC_W'(epg_pkg::QUANT_MANT) << sh;
	endfunction

	// quantum of one calibration pulse, counter quantum / multiplier
	function automatic logic [epg_pkg::ACC_W-1:0] epg_cf_quantum(
		input logic [1:0] sel,
		input logic       calib_scale_sel
	);
		logic [5:0] sh;
		sh = calib_scale_sel ? 6'(epg_pkg::CF_EXP_SCF_HI) : 6'(epg_pkg::CF_EXP_SCF_LO);
		sh = sh - {4'h0, sel};
		return epg_ctr_quantum(sel) >> sh;
	endfunction

	// pulse width: full width, or the half period when that is shorter
	function automatic logic [epg_pkg::TMR_W-1:0] epg_width(
		input logic [epg_pkg::TMR_W-1:0] half_per,
		input logic [epg_pkg::TMR_W-1:0] max_w
	);
		logic [epg_pkg::TMR_W-1:0] w;
		w = (half_per < max_w) ? half_per : max_w;
		if (w == '0) begin
			w = epg_pkg::TMR_W'(1);
		end
		return w;
	endfunction

	// ************************************************************
	// combinational next state
	// ************************************************************
	epg_pkg::epg_state_t st_ff;
	epg_pkg::epg_state_t nxt_st;

	logic [1:0]                sel;
	logic                      tick;
	logic                      loaded;
	logic [epg_pkg::ACC_W-1:0] pwr_ext;
	logic [epg_pkg::ACC_W-1:0] sum_ctr;
	logic [epg_pkg::ACC_W-1:0] sum_cf;
	logic [epg_pkg::ACC_W-1:0] q_ctr;
	logic [epg_pkg::ACC_W-1:0] q_cf;

	assign sel     = {i_base_freq_sel_hi, i_base_freq_sel_lo};
	// one accumulation per master clock rising edge
	assign tick    = i_master_clock_in & ~st_ff.mclk_d;
	assign loaded  = i_power >= epg_pkg::PWR_W'(epg_pkg::NOLOAD_MIN);
	assign pwr_ext = {{(epg_pkg::ACC_W-epg_pkg::PWR_W){1'b0}}, i_power};
	assign sum_ctr = st_ff.acc_ctr + pwr_ext;
	assign sum_cf  = st_ff.acc_cf + pwr_ext;
	assign q_ctr   = epg_ctr_quantum(sel);
	assign q_cf    = epg_cf_quantum(sel, i_calib_scale_sel);

	always_comb begin
		nxt_st        = st_ff;
		nxt_st.mclk_d = i_master_clock_in;

		// period counters saturate so a pulse after a long gap gets full width; reset clears them
		if (st_ff.ctr_per != '1) begin
			nxt_st.ctr_per = st_ff.ctr_per + 1'b1;
		end
		if (st_ff.cf_per != '1) begin
			nxt_st.cf_per = st_ff.cf_per + 1'b1;
		end

		// pulse timers release the outputs when they run out
		if (st_ff.ctr_tmr != '0) begin
			nxt_st.ctr_tmr = st_ff.ctr_tmr - 1'b1;
			if (st_ff.ctr_tmr == epg_pkg::TMR_W'(1)) begin
				nxt_st.pulse_a_n = epg_pkg::CTR_IDLE;
				nxt_st.pulse_b_n = epg_pkg::CTR_IDLE;
			end
		end
		if (st_ff.cf_tmr != '0) begin
			nxt_st.cf_tmr = st_ff.cf_tmr - 1'b1;
			if (st_ff.cf_tmr == epg_pkg::TMR_W'(1)) begin
				nxt_st.calib = epg_pkg::CF_IDLE;
			end
		end

		if (tick && loaded) begin
			if (sum_ctr >= q_ctr) begin
				nxt_st.acc_ctr = sum_ctr - q_ctr;
				nxt_st.pulse_a_n = st_ff.next_b;
				nxt_st.pulse_b_n = ~st_ff.next_b;
				nxt_st.next_b    = ~st_ff.next_b;
				// 275 ms, own period is two intervals
				nxt_st.ctr_tmr   = epg_width(st_ff.ctr_per, CTR_W_CYC);
				nxt_st.ctr_per   = '0;
			end else begin
				nxt_st.acc_ctr = sum_ctr;
			end
			if (sum_cf >= q_cf) begin
				nxt_st.acc_cf = sum_cf - q_cf;
				nxt_st.calib  = 1'b1;
				// 90 ms, or half the period when that is shorter
				nxt_st.cf_tmr = epg_width(st_ff.cf_per >> 1, CF_W_CYC);
				nxt_st.cf_per = '0;
			end else begin
				nxt_st.acc_cf = sum_cf;
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff           <= '0;
			st_ff.pulse_a_n <= epg_pkg::CTR_IDLE;
			st_ff.pulse_b_n <= epg_pkg::CTR_IDLE;
			st_ff.calib     <= epg_pkg::CF_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_counter_pulse_a_n = st_ff.pulse_a_n;
	assign o_counter_pulse_b_n = st_ff.pulse_b_n;
	assign o_calib_pulse_out   = st_ff.calib;

endmodule

// >>> testbench/epg_props.sv
`timescale 1ns/1ps
module epg_props #(
	parameter logic [31:0] CTR_W_CYC = 32'hC8,
	parameter logic [31:0] CF_W_CYC = 32'h3C
) (
	input wire logic	i_clk,
	input wire logic	i_nrst,
	input wire logic	i_master_clock_in,
	input wire logic [15:0]	i_power,
	input wire logic	o_counter_pulse_a_n,
	input wire logic	o_counter_pulse_b_n,
	input wire logic	o_calib_pulse_out
);
	logic [31:0]	cf_cnt_ff;
	logic [31:0]	a_cnt_ff;
	logic		last_a_ff;
	// run lengths so width limits can be bounded without long repetitions
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cf_cnt_ff <= '0;
			a_cnt_ff <= '0;
			last_a_ff <= 1'b0;
		end else begin
			cf_cnt_ff <= o_calib_pulse_out ? cf_cnt_ff + 1 : '0;
			a_cnt_ff <= o_counter_pulse_a_n ? '0 : a_cnt_ff + 1;
			last_a_ff <= !o_counter_pulse_a_n | (last_a_ff & o_counter_pulse_b_n);
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	a_drive_not_both: assert property (
		o_counter_pulse_a_n || o_counter_pulse_b_n) else $error("both low");
	a_drive_alternate: assert property (
		!(($fell(o_counter_pulse_a_n) && last_a_ff) ||
		($fell(o_counter_pulse_b_n) && !last_a_ff))) else $error("order");
	a_ctr_width_max: assert property (
		!o_counter_pulse_a_n |-> a_cnt_ff < CTR_W_CYC) else $error("a wide");
	a_cf_width_max: assert property (
		o_calib_pulse_out |-> cf_cnt_ff < CF_W_CYC) else $error("cf wide");
	a_cf_on_tick: assert property ($rose(o_calib_pulse_out) |->
		$past(i_master_clock_in) && !$past(i_master_clock_in, 2))
		else $error("cf off tick");
	a_ctr_on_tick: assert property (
		$fell(o_counter_pulse_a_n) || $fell(o_counter_pulse_b_n) |->
		$past(i_master_clock_in) && !$past(i_master_clock_in, 2))
		else $error("drive off tick");
	a_no_load_quiet: assert property ($rose(o_calib_pulse_out) ||
		$fell(o_counter_pulse_a_n) || $fell(o_counter_pulse_b_n) |->
		$past(i_power) != 16'h0) else $error("pulse at no load");
	a_reset_idle: assert property ($rose(i_nrst) |->
		o_counter_pulse_a_n && o_counter_pulse_b_n && !o_calib_pulse_out)
		else $error("not idle");
endmodule
bind epg_pulse_gen epg_props #(.CTR_W_CYC(CTR_W_CYC), .CF_W_CYC(CF_W_CYC))
	epg_props_inst (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_master_clock_in(i_master_clock_in), .i_power(i_power),
	.o_counter_pulse_a_n(o_counter_pulse_a_n),
	.o_counter_pulse_b_n(o_counter_pulse_b_n),
	.o_calib_pulse_out(o_calib_pulse_out));

// >>> testbench/epg_counter_model.sv
`timescale 1ns/1ps
module epg_counter_model (
	input wire logic	i_clk,
	input wire logic	i_nrst,
	input wire logic	i_a_n,
	input wire logic	i_b_n,
	input wire logic	i_cf,
	output logic [15:0]	o_steps,
	output logic [15:0]	o_cf_count
);
	logic [2:0]	prev_ff;
	// a step is taken on each falling drive edge, as a counter coil would
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prev_ff <= 3'h6;
			o_steps <= 16'h0;
			o_cf_count <= 16'h0;
		end else begin
			prev_ff <= {i_a_n, i_b_n, i_cf};
			o_steps <= o_steps + 16'(prev_ff[2] & !i_a_n) + 16'(prev_ff[1] & !i_b_n);
			o_cf_count <= o_cf_count + 16'(!prev_ff[0] & i_cf);
		end
	end
endmodule

// >>> testbench/epg_pulse_gen_tb_top.sv
`timescale 1ns/1ps
module epg_pulse_gen_tb_top;
	localparam logic [31:0] CFW = 32'h3C;
	logic		i_clk = 1'b0;
	logic		i_nrst = 1'b0;
	logic		mclk = 1'b0;
	logic [15:0]	pwr = 16'h0;
	logic [1:0]	sel = 2'h0;
	logic		calib_scale_sel = 1'b0;
	logic		a_n;
	logic		b_n;
	logic		cf;
	logic [15:0]	steps;
	logic [15:0]	cfs;
	int		err_count = 0;
	int		checks_done = 0;
	int		n;
	logic [5:0]	rows [8] = '{6'h06, 6'h0E, 6'h16, 6'h1E, 6'h26, 6'h2E, 6'h36, 6'h3E};
	epg_pulse_gen #(.CTR_W_CYC(32'hC8), .CF_W_CYC(CFW)) epg_pulse_gen_inst (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_master_clock_in(mclk),
		.i_power(pwr), .i_base_freq_sel_lo(sel[0]),
		.i_base_freq_sel_hi(sel[1]), .i_calib_scale_sel(calib_scale_sel),
		.o_counter_pulse_a_n(a_n), .o_counter_pulse_b_n(b_n),
		.o_calib_pulse_out(cf));
	epg_counter_model epg_counter_model_inst (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_a_n(a_n), .i_b_n(b_n), .i_cf(cf), .o_steps(steps), .o_cf_count(cfs));
	initial forever #2 i_clk = ~i_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) begin
			@(posedge i_clk);
			#1 mclk = 1'b1;
			@(posedge i_clk);
			#1 mclk = 1'b0;
		end
	endtask
	task automatic report_and_stop;
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_nrst = 1'b1;
		chk("idle", 32'h6, 32'({a_n, b_n, cf}));
		foreach (rows[k]) begin
			{sel, calib_scale_sel} = rows[k][5:3];
			tick(20);
			chk("row", 32'(rows[k][2:0]), 32'({a_n, b_n, cf}));
		end
		sel = 2'h3;
		calib_scale_sel = 1'b1;
		pwr = 16'hFFFF;
		n = 0;
		while (cf !== 1'b1 && n < 50000) begin
			tick(1);
			n++;
		end
		// full scale each tick against a quantum of full scale x 5 << 13
		chk("ticks", 32'hA000, 32'(n));
		n = 0;
		while (cf === 1'b1 && n < 1000) begin
			@(posedge i_clk);
			#1 n++;
		end
		chk("width", CFW, 32'(n));
		chk("cf count", 32'h1, 32'(cfs));
		// drive steps need ~650k ticks here, far beyond this run
		chk("steps", 32'h0, 32'(steps));
		i_nrst = 1'b0;
		#1 chk("reset", 32'h6, 32'({a_n, b_n, cf}));
		report_and_stop();
	end
endmodule
